// ### src/cfg_bank_pkg.sv
// Constants for the power-up sequencing and low configuration register bank
package cfg_bank_pkg;

	// Register table: index i holds the offset and the value after reset
	localparam int NUM_REGS = 30;
	localparam logic [NUM_REGS-1:0][7:0] REG_OFFSET = {
		8'h75, 8'h23, 8'h22, 8'h21, 8'h1E, 8'h1D, 8'h1C, 8'h1B, 8'h1A, 8'h19,
		8'h18, 8'h16, 8'h14, 8'h13, 8'h12, 8'h11, 8'h10, 8'h0F, 8'h0E, 8'h0D,
		8'h0C, 8'h0B, 8'h0A, 8'h09, 8'h08, 8'h07, 8'h03, 8'h02, 8'h01, 8'h00};
	localparam logic [NUM_REGS-1:0][7:0] REG_RESET = {
		8'h80, 8'h51, 8'h31, 8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h37,
		8'hFF, 8'h00, 8'h01, 8'hFC, 8'h42, 8'hCE, 8'h7F, 8'h00, 8'h00, 8'h00,
		8'h40, 8'h00, 8'h00, 8'h00, 8'hE0, 8'h00, 8'h00, 8'h40, 8'h81, 8'h20};

	// Indices of the registers that steer this block
	localparam int IDX_CONFIG_ONE     = 1;
	localparam int IDX_CONFIG_THREE   = 3;
	localparam int IDX_FREEWHEEL_EN   = 25;
	localparam int IDX_BATT_LOW_LIMIT = 29;

	// Field positions
	localparam int SETUP_DONE_BIT = 5;
	localparam int XOR_MODE_BIT   = 6;

	// Board-test tree width
	localparam int XOR_WIDTH = 16;

	// Drive-two silent-bus timeout, longest time so rounded down
	localparam longint FAN2_TIMEOUT_MS     = 4600;
	localparam longint CLK_FREQ_KHZ        = 125000;
	localparam longint FAN2_TIMEOUT_CYCLES = FAN2_TIMEOUT_MS * CLK_FREQ_KHZ;
	localparam int     TIMER_WIDTH         = 30;

endpackage : cfg_bank_pkg

// ### src/smbus_target.sv
// Byte-level SMBus target that turns bus transfers into register strobes
`timescale 1ns/100ps
module smbus_target
	import cfg_bank_pkg::*;
#(
	parameter logic [6:0] BUS_ADDR = 7'h2A
) (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_oe,
	output logic            wr_pulse,
	output logic [7:0]      wr_addr,
	output logic [7:0]      wr_data,
	output logic [7:0]      rd_ptr,
	input  wire logic [7:0] rd_data,
	output logic            hit_pulse
);
	typedef enum logic [8:0] {
		ST_IDLE  = 9'h001, ST_ADDR  = 9'h002, ST_AACK = 9'h004,
		ST_PTR   = 9'h008, ST_PACK  = 9'h010, ST_WDATA = 9'h020,
		ST_WACK  = 9'h040, ST_RDATA = 9'h080, ST_RACK = 9'h100
	} tgt_state_t;

	typedef struct packed {
		logic       scl_s1, scl_s2, scl_d;
		logic       sda_s1, sda_s2, sda_d;
		tgt_state_t st;
		logic [3:0] cnt;
		logic [7:0] shreg;
		logic [7:0] ptr;
		logic       rnw;
		logic       oe;
		logic       wr;
		logic       hit;
		logic       load;
	} tgt_t;

	tgt_t s, next_s;

	// Pin synchronisers, edge and start/stop detection, protocol steps
	always_comb begin
		next_s        = s;
		next_s.wr     = 1'b0;
		next_s.hit    = 1'b0;
		next_s.scl_s1 = scl_in;
		next_s.scl_s2 = s.scl_s1;
		next_s.scl_d  = s.scl_s2;
		next_s.sda_s1 = sda_in;
		next_s.sda_s2 = s.sda_s1;
		next_s.sda_d  = s.sda_s2;
		if (s.scl_s2 && s.scl_d && s.sda_d && !s.sda_s2) begin
			next_s.st  = ST_ADDR; // Start or repeated start
			next_s.cnt = 4'h0;
			next_s.oe  = 1'b0;
		end else if (s.scl_s2 && s.scl_d && !s.sda_d && s.sda_s2) begin
			next_s.st = ST_IDLE; // Stop
			next_s.oe = 1'b0;
		end else if (s.scl_s2 && !s.scl_d) begin
			unique case (s.st)
				ST_ADDR, ST_PTR, ST_WDATA: begin
					next_s.shreg = {s.shreg[6:0], s.sda_s2};
					next_s.cnt   = s.cnt + 4'h1;
				end
				ST_RDATA: begin
					next_s.shreg = {s.shreg[6:0], 1'b0};
					next_s.cnt   = s.cnt + 4'h1;
				end
				ST_RACK: begin
					if (!s.sda_s2) begin
						next_s.ptr  = s.ptr + 8'h01;
						next_s.load = 1'b1;
					end else begin
						next_s.st = ST_IDLE; // Host ended the read
					end
				end
				ST_IDLE, ST_AACK, ST_PACK, ST_WACK: ;
			endcase
		end else if (!s.scl_s2 && s.scl_d) begin
			unique case (s.st)
				ST_ADDR: begin
					if (s.cnt == 4'h8) begin
						if (s.shreg[7:1] == BUS_ADDR) begin
							next_s.st  = ST_AACK;
							next_s.oe  = 1'b1;
							next_s.rnw = s.shreg[0];
							next_s.hit = 1'b1;
						end else begin
							next_s.st = ST_IDLE;
						end
					end
				end
				ST_AACK: begin
					next_s.cnt = 4'h0;
					if (s.rnw) begin
						next_s.st    = ST_RDATA;
						next_s.shreg = rd_data;
						next_s.oe    = !rd_data[7];
					end else begin
						next_s.st = ST_PTR;
						next_s.oe = 1'b0;
					end
				end
				ST_PTR: begin
					if (s.cnt == 4'h8) begin
						next_s.ptr = s.shreg;
						next_s.oe  = 1'b1;
						next_s.st  = ST_PACK;
					end
				end
				ST_WDATA: begin
					if (s.cnt == 4'h8) begin
						next_s.wr = 1'b1;
						next_s.oe = 1'b1;
						next_s.st = ST_WACK;
					end
				end
				ST_PACK, ST_WACK: begin
					next_s.oe  = 1'b0;
					next_s.cnt = 4'h0;
					next_s.st  = ST_WDATA;
					if (s.st == ST_WACK) begin
						next_s.ptr = s.ptr + 8'h01; // Auto-increment
					end
				end
				ST_RDATA: begin
					if (s.cnt == 4'h8) begin
						next_s.oe = 1'b0;
						next_s.st = ST_RACK;
					end else begin
						next_s.oe = !s.shreg[7];
					end
				end
				ST_RACK: begin
					if (s.load) begin
						next_s.load  = 1'b0;
						next_s.cnt   = 4'h0;
						next_s.shreg = rd_data;
						next_s.oe    = !rd_data[7];
						next_s.st    = ST_RDATA;
					end
				end
				ST_IDLE: ;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1,
				sda_d: 1'b1, st: ST_IDLE, cnt: 4'h0, shreg: 8'h00, ptr: 8'h00,
				default: 1'b0};
		end else if (clk_en) begin
			s <= next_s;
		end
	end

	assign sda_oe    = s.oe;
	assign wr_pulse  = s.wr;
	assign wr_addr   = s.ptr;
	assign wr_data   = s.shreg;
	assign rd_ptr    = s.ptr;
	assign hit_pulse = s.hit;

endmodule : smbus_target

// ### src/powerup_setup_config_bank.sv
// Power-up sequencing, configuration register bank and board-test tree
// What this block does
// [R1] The dedicated diode channel is monitored from power-up without any host setup.
// [R2] The main rail monitor input is monitored from power-up regardless of setup-done.
// [R3] The fan quiet start-up counter is held until the main rail is seen on.
// [R4] The battery input is measured from power-up, before setup-done is set.
// [R5] A battery reading below its low limit (reset 0x80) switches the intrusion detector off.
// [R6] Fan drives 1, 3 and 4 float high at power-up so fans run at full speed.
// [R7] Drive 2 starts off, goes full speed if the bus stays silent 4.6 s after rail on.
// [R8] All other channels wait for the setup-done bit in register 0x01 bit 5.
// [R9] The host picks pin options, programs everything else, and sets setup-done last.
// [R10] Bit 6 of register 0x03 puts the block in board-test XOR tree mode.
// [R11] In that mode the XOR of the test pins appears on an open-drain output.
// [R12] The host sets every test pin to its digital input function before the test.
// [R13] Register 0x1E holds one free-wheel test enable per fan and resets to zero.
`timescale 1ns/100ps
module powerup_setup_config_bank
	import cfg_bank_pkg::*;
#(
	parameter int unsigned  TIMEOUT_CYCLES = 32'(FAN2_TIMEOUT_CYCLES),
	parameter logic [6:0]   BUS_ADDR       = 7'h2A // Arbitrary bus address
) (
	input  wire logic                                clk_sys,
	input  wire logic                                rst_n,
	input  wire logic                                clk_en,
	input  wire logic                                scl_in,
	input  wire logic                                sda_in,
	output logic                                     sda_out,
	output logic                                     sda_oe,
	input  wire logic                                main_rail_monitor_input,
	input  wire logic [7:0]                          battery_reading,
	input  wire logic                                battery_valid,
	input  wire logic [3:0]                          fan_pwm_level,
	input  wire logic [cfg_bank_pkg::XOR_WIDTH-1:0]  xor_test_pins,
	output logic                                     diode_monitor_enable,
	output logic                                     rail_monitor_enable,
	output logic                                     battery_monitor_enable,
	output logic                                     quiet_start_run,
	output logic                                     intrusion_detector_enable,
	output logic                                     channel_monitor_enable,
	output logic [3:0]                               fan_drive_out,
	output logic [3:0]                               fan_drive_oe,
	output logic                                     xor_tree_out,
	output logic                                     xor_tree_oe,
	output logic [7:0]                               freewheel_enable
);
	import cfg_bank_pkg::*;

	typedef struct packed {
		logic                             early_mon;
		logic                             rail_s1, rail_s2;
		logic [XOR_WIDTH-1:0]             xor_s1, xor_s2;
		logic [NUM_REGS-1:0][7:0]         regs;
		logic [TIMER_WIDTH-1:0]           timer;
		logic                             timed_out;
		logic                             bus_seen;
		logic                             intr_en;
		logic                             quiet_run;
		logic                             mon_rest;
		logic [3:0]                       drv_out;
		logic [3:0]                       drv_oe;
		logic                             xor_oe;
	} bank_t;

	bank_t s, next_s;

	logic       tgt_sda_oe;
	logic       wr_pulse;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] rd_ptr;
	logic [7:0] rd_data;
	logic       hit_pulse;
	logic       setup_done;
	logic       xor_mode;
	logic       fan2_level;

	// Register access over the two-wire management bus
	smbus_target #(
		.BUS_ADDR (BUS_ADDR)
	) u_target (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.clk_en    (clk_en),
		.scl_in    (scl_in),
		.sda_in    (sda_in),
		.sda_oe    (tgt_sda_oe),
		.wr_pulse  (wr_pulse),
		.wr_addr   (wr_addr),
		.wr_data   (wr_data),
		.rd_ptr    (rd_ptr),
		.rd_data   (rd_data),
		.hit_pulse (hit_pulse)
	);

	// Read mux; unmapped offsets read as zero
	always_comb begin
		rd_data = 8'h00;
		for (int i = 0; i < NUM_REGS; i++) begin
			if (REG_OFFSET[i] == rd_ptr) begin
				rd_data = s.regs[i];
			end
		end
	end

	assign setup_done = s.regs[IDX_CONFIG_ONE][SETUP_DONE_BIT];
	assign xor_mode   = s.regs[IDX_CONFIG_THREE][XOR_MODE_BIT];

	// Drive two: off, then full speed on a silent bus, else programmed
	always_comb begin
		if (s.bus_seen) begin
			fan2_level = fan_pwm_level[1]; // R7
		end else begin
			fan2_level = s.timed_out; // R7
		end
	end

	// Next-state logic for the whole bank
	always_comb begin
		next_s           = s;
		next_s.early_mon = 1'b1; // R1 R2 R4
		next_s.rail_s1   = main_rail_monitor_input;
		next_s.rail_s2   = s.rail_s1;
		next_s.xor_s1    = xor_test_pins;
		next_s.xor_s2    = s.xor_s1;
		// Register writes; unmapped offsets are ignored
		for (int i = 0; i < NUM_REGS; i++) begin
			if (wr_pulse && REG_OFFSET[i] == wr_addr) begin
				next_s.regs[i] = wr_data; // R13
			end
		end
		// Any addressed transfer counts as bus activity and stays latched
		if (hit_pulse) begin
			next_s.bus_seen = 1'b1; // R7
		end
		// Silent-bus timer runs only once the main rail is on
		if (s.rail_s2 && !s.bus_seen && !s.timed_out) begin
			if (s.timer == TIMER_WIDTH'(TIMEOUT_CYCLES - 1)) begin
				next_s.timed_out = 1'b1; // R7
			end else begin
				next_s.timer = s.timer + 1'b1;
			end
		end
		next_s.quiet_run = s.rail_s2; // R3
		// Intrusion detector follows each battery reading against its limit
		if (battery_valid) begin
			next_s.intr_en = battery_reading >= s.regs[IDX_BATT_LOW_LIMIT]; // R5
		end
		next_s.mon_rest = setup_done; // R8
		// Shared drive pins released (pulled high) until setup is done
		for (int k = 0; k < 4; k++) begin
			if (k == 1) begin
				next_s.drv_out[k] = fan2_level; // R7
				next_s.drv_oe[k]  = 1'b1;
			end else begin
				next_s.drv_out[k] = 1'b0;
				next_s.drv_oe[k]  = setup_done && !fan_pwm_level[k]; // R6
			end
		end
		// Test pins must be in digital input mode for this to mean anything
		next_s.xor_oe = xor_mode && !(^s.xor_s2); // R10 R11
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s <= '{early_mon: 1'b1, xor_s1: '0, xor_s2: '0, regs: REG_RESET,
				timer: '0, drv_out: 4'h0, drv_oe: 4'h0, default: 1'b0};
		end else if (clk_en) begin
			s <= next_s;
		end
	end

	// Outputs straight from flip-flops
	assign diode_monitor_enable      = s.early_mon;
	assign rail_monitor_enable       = s.early_mon;
	assign battery_monitor_enable    = s.early_mon;
	assign quiet_start_run           = s.quiet_run;
	assign intrusion_detector_enable = s.intr_en;
	assign channel_monitor_enable    = s.mon_rest;
	assign fan_drive_out             = s.drv_out;
	assign fan_drive_oe              = s.drv_oe;
	assign xor_tree_out              = 1'b0; // Open drain pulls low only
	assign xor_tree_oe               = s.xor_oe;
	assign sda_out                   = 1'b0;
	assign sda_oe                    = tgt_sda_oe;
	assign freewheel_enable          = s.regs[IDX_FREEWHEEL_EN];

	// Early channels are live from reset on
	a_diode_early_mon: // R1
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		diode_monitor_enable && rail_monitor_enable)
		else $error("diode or rail monitoring not live");

	a_rail_mon_free: // R2
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		!setup_done |-> rail_monitor_enable)
		else $error("rail monitoring waits for setup");

	a_quiet_gate_rail: // R3
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		$past(clk_en) |-> quiet_start_run == $past(s.rail_s2))
		else $error("quiet start counter not gated by rail");

	a_batt_early_mon: // R4
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		!channel_monitor_enable |-> battery_monitor_enable)
		else $error("battery not measured before setup");

	a_intr_low_batt: // R5
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && battery_valid && battery_reading < s.regs[IDX_BATT_LOW_LIMIT]
		|=> !intrusion_detector_enable)
		else $error("intrusion detector left on with low battery");

	a_shared_float_high: // R6
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		$past(clk_en) && !$past(setup_done) |-> fan_drive_oe[0] == 1'b0
		&& fan_drive_oe[2] == 1'b0 && fan_drive_oe[3] == 1'b0)
		else $error("shared drive pin driven before setup");

	a_fan2_default_off: // R7
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		$past(rst_n) && !s.bus_seen && !s.timed_out |-> !fan_drive_out[1] && fan_drive_oe[1])
		else $error("drive two not off by default");

	a_fan2_timeout_fire: // R7
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && s.rail_s2 && !s.bus_seen && !hit_pulse
		&& s.timer == TIMER_WIDTH'(TIMEOUT_CYCLES - 1)
		|=> s.timed_out ##1 (!clk_en || fan_drive_out[1]))
		else $error("drive two not at full speed after silent bus");

	a_rest_wait_setup: // R8
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		$past(clk_en) |-> channel_monitor_enable == $past(setup_done))
		else $error("channels monitored without setup done");

	a_xor_tree_out: // R11
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		$past(clk_en) && $past(xor_mode) |-> xor_tree_oe == !(^$past(s.xor_s2)))
		else $error("tree output does not match pin parity");

	a_xor_mode_off: // R10
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		$past(clk_en) && !$past(xor_mode) |-> !xor_tree_oe)
		else $error("tree output active outside test mode");

	a_freewheel_write: // R13
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && wr_pulse && wr_addr == REG_OFFSET[IDX_FREEWHEEL_EN]
		|=> freewheel_enable == $past(wr_data))
		else $error("free-wheel enable write lost");

	// Drive two, bus activity mark and silent-bus timer
	a_fan2_pin_driven: // R7
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		$past(rst_n) |-> fan_drive_oe[1])
		else $error("drive two pin released");

	a_fan2_prog_level: // R7
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		$past(clk_en) && $past(s.bus_seen) |-> fan_drive_out[1] == $past(fan_pwm_level[1]))
		else $error("drive two ignores its level");

	a_fan2_silent_level: // R7
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		$past(clk_en) && !$past(s.bus_seen) |-> fan_drive_out[1] == $past(s.timed_out))
		else $error("drive two ignores the timeout");

	a_bus_seen_held: // R7
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		$past(s.bus_seen) |-> s.bus_seen)
		else $error("bus activity mark lost");

	a_hit_marks_bus: // R7
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && hit_pulse |=> s.bus_seen)
		else $error("addressed transfer not marked");

	a_timeout_held: // R7
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		$past(s.timed_out) |-> s.timed_out)
		else $error("timeout mark lost");

	a_timer_hold_rail: // R7
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		!s.rail_s2 |=> s.timer == $past(s.timer))
		else $error("timer runs with the rail off");

	a_no_early_timeout: // R7
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		!s.timed_out && s.timer != TIMER_WIDTH'(TIMEOUT_CYCLES - 1) |=> !s.timed_out)
		else $error("timeout before the full count");

	// Intrusion detector against the battery limit
	a_intr_batt_ok: // R5
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && battery_valid && battery_reading >= s.regs[IDX_BATT_LOW_LIMIT]
		|=> intrusion_detector_enable)
		else $error("intrusion detector off with good battery");

	a_intr_no_reading: // R5
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && !battery_valid |=> $stable(intrusion_detector_enable))
		else $error("intrusion detector moved without a reading");

	a_batt_limit_write: // R5
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && wr_pulse && wr_addr == REG_OFFSET[IDX_BATT_LOW_LIMIT]
		|=> s.regs[IDX_BATT_LOW_LIMIT] == $past(wr_data))
		else $error("battery limit write lost");

	// Shared drives after setup follow their levels
	a_shared_pull_low: // R6
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		$past(clk_en) && $past(setup_done) |-> fan_drive_oe[0] == !$past(fan_pwm_level[0])
		&& fan_drive_oe[2] == !$past(fan_pwm_level[2])
		&& fan_drive_oe[3] == !$past(fan_pwm_level[3]))
		else $error("shared drive level not followed");

	// Register writes, reads and the freeze
	a_setup_bit_write: // R8
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && wr_pulse && wr_addr == REG_OFFSET[IDX_CONFIG_ONE]
		|=> setup_done == $past(wr_data[SETUP_DONE_BIT]))
		else $error("setup-done write lost");

	a_xor_bit_write: // R10
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && wr_pulse && wr_addr == REG_OFFSET[IDX_CONFIG_THREE]
		|=> xor_mode == $past(wr_data[XOR_MODE_BIT]))
		else $error("test mode write lost");

	a_regs_hold:
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		clk_en && !wr_pulse |=> $stable(s.regs))
		else $error("register changed without a write");

	a_rd_unmapped_zero:
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		rd_ptr == 8'h05 |-> rd_data == 8'h00)
		else $error("unmapped offset reads nonzero");

	a_freeze_state:
	assert property (@(posedge clk_sys) disable iff (!rst_n)
		!clk_en |=> $stable(s) && $stable(sda_oe))
		else $error("state moved with the clock enable low");

endmodule : powerup_setup_config_bank

// ### sim/smbus_host_model.sv
// SMBus host model that runs register transfers over an open-drain pair
`timescale 1ns/100ps
module smbus_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h2A, // Arbitrary bus address
	parameter int         HALF     = 8
) (
	input  wire logic clk_sys,
	input  wire logic sda_dev_oe,
	output logic      scl_line,
	output logic      sda_line
);
	logic scl_drv;
	logic sda_rel;
	// Only the host drives SCL; SDA is a wired AND under a pull-up
	assign scl_line = scl_drv;
	assign sda_line = sda_rel & ~sda_dev_oe;
	initial begin
		scl_drv = 1'b1;
		sda_rel = 1'b1;
	end
	// One SCL half period, changes land on falling clock edges
	task automatic half;
		repeat (HALF) @(negedge clk_sys);
	endtask : half
	// Start or repeated start, SDA falls while SCL is high
	task automatic start;
		sda_rel = 1'b1;
		half();
		scl_drv = 1'b1;
		half();
		sda_rel = 1'b0;
		half();
		scl_drv = 1'b0;
		half();
	endtask : start
	// Stop, SDA rises while SCL is high, then the bus stands idle
	task automatic stop;
		sda_rel = 1'b0;
		half();
		scl_drv = 1'b1;
		half();
		sda_rel = 1'b1;
		half();
	endtask : stop
	// Bit clocked out on SDA, read back at the end of the high phase, just before SCL falls
	task automatic bit_cycle(input logic b, output logic seen);
		sda_rel = b;
		half();
		scl_drv = 1'b1;
		half();
		seen = sda_line;
		scl_drv = 1'b0;
	endtask : bit_cycle
	// Byte out MSB first, then the acknowledge slot with SDA released
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(b[i], s);
		end
		bit_cycle(1'b1, s);
		ack = ~s;
	endtask : send_byte
	// Byte in MSB first, then our own acknowledge or refusal
	task automatic recv_byte(input logic nack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(1'b1, b[i]);
		end
		bit_cycle(nack, s);
	endtask : recv_byte
	// Single-byte register write to any device address
	task automatic write_reg(input logic [6:0] a, input logic [7:0] off, input logic [7:0] d,
		output logic ok);
		logic k0, k1, k2;
		start();
		send_byte({a, 1'b0}, k0);
		send_byte(off, k1);
		send_byte(d, k2);
		stop();
		ok = k0 & k1 & k2;
	endtask : write_reg
	// Register read: pointer write, repeated start, one byte ended by a refusal
	task automatic read_reg(input logic [7:0] off, output logic [7:0] q, output logic ok);
		logic k0, k1, k2;
		start();
		send_byte({DEV_ADDR, 1'b0}, k0);
		send_byte(off, k1);
		start();
		send_byte({DEV_ADDR, 1'b1}, k2);
		recv_byte(1'b1, q);
		stop();
		ok = k0 & k1 & k2;
	endtask : read_reg
endmodule : smbus_host_model

// ### sim/powerup_setup_config_bank_test.sv
// Self-checking bench for the power-up sequencing and configuration bank
`timescale 1ns/100ps
module powerup_setup_config_bank_test;
	import cfg_bank_pkg::*;
	localparam int unsigned TMO  = 400;
	localparam logic [6:0]  ADDR = 7'h2A; // Arbitrary bus address
	localparam logic [7:0]  OFFS [30] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h08, 8'h09,
		8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h16,
		8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h21, 8'h22, 8'h23, 8'h75};
	localparam logic [7:0]  RSTV [30] = '{8'h20, 8'h81, 8'h40, 8'h00, 8'h00, 8'hE0, 8'h00,
		8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h7F, 8'hCE, 8'h42, 8'hFC, 8'h01, 8'h00,
		8'hFF, 8'h37, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h11, 8'h31, 8'h51, 8'h80};
	localparam logic [15:0] PATS [4] = '{16'h0000, 16'h0001, 16'h8421, 16'hFFFE};
	logic        clk_sys, rst_n, clk_en, scl, sda, sda_out, sda_oe, rail, batt_valid, ok;
	logic [7:0]  batt_code, freewheel_enable, q;
	logic [3:0]  fan_pwm_level, fan_drive_out, fan_drive_oe;
	logic [15:0] xor_pins;
	logic        diode_en, rail_en, batt_en, quiet, intr, chan, xor_out, xor_oe;
	int          errors, n_checks;
	wire logic [7:0] stat = {diode_en, rail_en, batt_en, chan, intr, quiet, fan_drive_oe[0],
		fan_drive_out[1]};

	powerup_setup_config_bank #(.TIMEOUT_CYCLES(TMO), .BUS_ADDR(ADDR)) dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .main_rail_monitor_input(rail),
		.battery_reading(batt_code), .battery_valid(batt_valid), .fan_pwm_level(fan_pwm_level),
		.xor_test_pins(xor_pins), .diode_monitor_enable(diode_en), .rail_monitor_enable(rail_en),
		.battery_monitor_enable(batt_en), .quiet_start_run(quiet),
		.intrusion_detector_enable(intr), .channel_monitor_enable(chan),
		.fan_drive_out(fan_drive_out), .fan_drive_oe(fan_drive_oe), .xor_tree_out(xor_out),
		.xor_tree_oe(xor_oe), .freewheel_enable(freewheel_enable));

	smbus_host_model #(.DEV_ADDR(ADDR)) host (
		.clk_sys(clk_sys), .sda_dev_oe(sda_oe), .scl_line(scl), .sda_line(sda));

	// Clock of 8 ns period
	initial clk_sys = 1'b0;
	always #4 clk_sys = ~clk_sys;

	// Comparison of a seen value against the expected one
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] off, input logic [7:0] d);
		host.write_reg(ADDR, off, d, ok);
		check(8'(ok), 8'h01, "write acknowledged");
	endtask : wr
	task automatic rd(input logic [7:0] off, input logic [7:0] exp);
		host.read_reg(off, q, ok);
		check({7'h00, ok}, 8'h01, "read acknowledged");
		check(q, exp, "read data");
	endtask : rd
	// One-cycle battery reading, then the settled detector state
	task automatic batt(input logic [7:0] code, input logic exp);
		batt_code = code;
		batt_valid = 1'b1;
		@(negedge clk_sys);
		batt_valid = 1'b0;
		repeat (3) @(negedge clk_sys);
		check(8'(intr), 8'(exp), "intrusion detector");
	endtask : batt
	task automatic do_reset;
		rst_n = 1'b0;
		repeat (4) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (3) @(negedge clk_sys);
	endtask : do_reset
	task automatic done_test(input string name);
		$display("Test %s finished, %0d mismatches so far", name, errors);
	endtask : done_test
	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test

	// Watchdog well beyond the expected run length
	initial begin
		repeat (90000) @(posedge clk_sys);
		errors++;
		$display("Error at %0t: run did not finish", $time);
		stop_test();
	end

	// Test sequence
	initial begin
		errors = 0;
		n_checks = 0;
		clk_en = 1'b1;
		rail = 1'b0;
		batt_valid = 1'b0;
		batt_code = 8'h00;
		fan_pwm_level = 4'b0000;
		xor_pins = 16'h0000;
		do_reset();
		check(stat, 8'hE0, "power-up state");
		check({fan_drive_oe, fan_drive_out}, 8'h20, "power-up drives");
		check({7'h00, sda_out}, 8'h00, "data pin level");
		repeat (500) @(negedge clk_sys);
		check(8'(fan_drive_out[1]), 8'h00, "drive two, rail low");
		rail = 1'b1;
		repeat (4) @(negedge clk_sys);
		check(8'(quiet), 8'h01, "quiet start runs");
		repeat (394) @(negedge clk_sys);
		check(8'(fan_drive_out[1]), 8'h00, "drive two before timeout");
		repeat (14) @(negedge clk_sys);
		check(8'(fan_drive_out[1]), 8'h01, "drive two after timeout");
		done_test("silent bus");
		for (int i = 0; i < 30; i++) rd(OFFS[i], RSTV[i]);
		fan_pwm_level = 4'b0010;
		repeat (3) @(negedge clk_sys);
		check(8'(fan_drive_out[1]), 8'h01, "drive two programmed high");
		fan_pwm_level = 4'b0000;
		repeat (3) @(negedge clk_sys);
		check(8'(fan_drive_out[1]), 8'h00, "drive two programmed low");
		wr(8'h1E, 8'hA5);
		rd(8'h1E, 8'hA5);
		check(freewheel_enable, 8'hA5, "free-wheel enables");
		wr(8'h05, 8'h5A);
		rd(8'h05, 8'h00);
		host.write_reg(7'h2B, 8'h1E, 8'h00, ok);
		check(8'(ok), 8'h00, "foreign address refused");
		rd(8'h1E, 8'hA5);
		done_test("register access");
		batt(8'h7F, 1'b0);
		batt(8'h80, 1'b1);
		wr(8'h75, 8'h90);
		batt(8'h8F, 1'b0);
		batt(8'h90, 1'b1);
		clk_en = 1'b0;
		batt(8'h00, 1'b1);
		clk_en = 1'b1;
		done_test("battery");
		wr(8'h14, 8'h01);
		check(8'(chan), 8'h00, "channels wait");
		wr(8'h01, 8'hA1);
		repeat (3) @(negedge clk_sys);
		check(8'(chan), 8'h01, "channels enabled");
		check(8'(fan_drive_oe), 8'h0F, "shared drives pulled");
		fan_pwm_level = 4'b1101;
		repeat (3) @(negedge clk_sys);
		check(8'(fan_drive_oe), 8'h02, "shared drives released");
		done_test("setup done");
		wr(8'h13, 8'h00);
		wr(8'h03, 8'h40);
		for (int i = 0; i < 4; i++) begin
			xor_pins = PATS[i];
			repeat (5) @(negedge clk_sys);
			check(8'({xor_out, xor_oe}), {7'h00, ~^PATS[i]}, "tree output");
		end
		wr(8'h03, 8'h00);
		xor_pins = 16'h0000;
		repeat (5) @(negedge clk_sys);
		check(8'(xor_oe), 8'h00, "tree mode off");
		done_test("board test");
		rail = 1'b0;
		do_reset();
		wr(8'h1E, 8'h00);
		rail = 1'b1;
		repeat (420) @(negedge clk_sys);
		check(8'(fan_drive_out[1]), 8'h00, "drive two after early transfer");
		done_test("early transfer");
		stop_test();
	end
endmodule : powerup_setup_config_bank_test
